// >>> hw/fscic_ctrl.sv
// Floating-point, packed-extension, cache and init control flags
// Function
// - Hardware reset clears trap-all, monitor and error-select flags in control word zero.
// - Trap-all set faults every floating-point instruction; clear executes it on the unit.
// - Wait faults only when monitor flag and task-switched flag are both set.
// - Error-select set reports unmasked errors internally, clear via external interrupt.
// - Trap-all clear with no unit, coprocessor or emulator: floating-point hangs device.
// - Variant without floating-point hardware faults every floating-point instruction.
// - Reset sets cache-disable and no-writethrough; caches enable only when both clear.
// - After reset every internal cache line is invalid.
// - Model-specific registers are reachable only by dedicated read and write instructions.
// - Reset zeroes range type registers; zero selects the uncached type.
// - Feature result: bit 25, bit 26 packed extensions, bit 24 full-state save.
// - Feature flags load into data register when accumulator is 1; bit 19 flush.
// - Reset loads packed control/status with 1F80H; soft init leaves it unchanged.
`include "fscic_defs.svh"
module fscic_ctrl #(
    parameter bit HAS_FPU = 1'b1,
    parameter int MSR_NUM = 16,
    parameter int MTRR_NUM = 4,
    parameter int LINES = 8,
    parameter bit FEAT_FLUSH = 1'b1,
    parameter bit FEAT_FXSR = 1'b1,
    parameter bit FEAT_PFX1 = 1'b1,
    parameter bit FEAT_PFX2 = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_soft_init,
    input wire logic i_cw0_wr,
    input wire logic [31:0] i_cw0_wdata,
    input wire logic i_task_switch,
    input wire logic i_cw4_wr,
    input wire logic [31:0] i_cw4_wdata,
    input wire logic i_simd_wr,
    input wire logic [31:0] i_simd_wdata,
    input wire fscic_pkg::fscic_req_t i_req,
    input wire logic i_fpu_present,
    input wire logic i_coproc_present,
    input wire logic i_emulator_present,
    input wire logic i_unmasked_exc,
    input wire logic i_line_fill,
    input wire logic [$clog2(LINES)-1:0] i_line_idx,
    output logic [31:0] o_control_word_zero,
    output logic [31:0] o_control_word_four,
    output logic [31:0] o_simd_fp_control_status,
    output logic o_cache_enable,
    output logic [LINES-1:0] o_line_valid,
    output logic [MTRR_NUM-1:0] o_range_uncached,
    output logic o_done,
    output logic o_device_unavailable_fault,
    output logic o_fp_exec,
    output logic o_hung,
    output logic o_fp_err_internal,
    output logic o_fp_err_external,
    output logic [31:0] o_data_reg_d,
    output logic [63:0] o_msr_rdata
);
    localparam int IW = $clog2(MSR_NUM);

    // ************************************************
    // Control words
    // ************************************************
    logic [31:0] cw0_q, cw0_d, cw4_q, cw4_d, simd_q, simd_d;
    logic trap_all, monitor, err_sel, ts_flag;

    assign trap_all = cw0_q[`FSCIC_CW0_TRAP_ALL];
    assign monitor = cw0_q[`FSCIC_CW0_MONITOR];
    assign err_sel = cw0_q[`FSCIC_CW0_ERR_SEL];
    assign ts_flag = cw0_q[`FSCIC_CW0_TASK_SW];

    always_comb begin
        cw0_d = cw0_q;
        cw4_d = cw4_q;
        simd_d = simd_q;
        if (i_soft_init) begin
            // Soft init keeps cache flags, drops the rest
            cw0_d = cw0_q & `FSCIC_CW0_KEEP;
        end else if (i_cw0_wr) begin
            cw0_d = i_cw0_wdata;
        end
        // Task switch event wins over a same-cycle write
        if (i_task_switch) begin
            cw0_d[`FSCIC_CW0_TASK_SW] = 1'b1;
        end
        if (i_cw4_wr) begin
            cw4_d = i_cw4_wdata;
        end
        if (i_simd_wr) begin
            simd_d = i_simd_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cw0_q <= `FSCIC_CW0_RST;
            cw4_q <= `FSCIC_CW4_RST;
            simd_q <= `FSCIC_SIMD_RST;
        end else begin
            cw0_q <= cw0_d;
            cw4_q <= cw4_d;
            simd_q <= simd_d;
        end
    end

    assign o_control_word_zero = cw0_q;
    assign o_control_word_four = cw4_q;
    assign o_simd_fp_control_status = simd_q;
    assign o_cache_enable = ~cw0_q[`FSCIC_CW0_CACHE_DIS] & ~cw0_q[`FSCIC_CW0_NO_WT];

    // ************************************************
    // Cache line valid bits
    // ************************************************
    logic [LINES-1:0] valid_q, valid_d;
    generate
        for (genvar g = 0; g < LINES; g++) begin : g_line
            // Fills while disabled are dropped: nothing was cached
            assign valid_d[g] = valid_q[g] |
                (i_line_fill & o_cache_enable & (i_line_idx == g));
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            valid_q <= '0;
        end else begin
            valid_q <= valid_d;
        end
    end
    assign o_line_valid = valid_q;

    // ************************************************
    // Instruction dispatch
    // ************************************************
    fscic_pkg::fscic_state_t st_q, st_d;
    logic take, is_fp, is_wait, fault, hang;
    logic done_q, done_d, flt_q, flt_d, exe_q, exe_d;
    logic [31:0] dreg_q, dreg_d;
    logic [63:0] rd_q, rd_d;
    logic [63:0] msr_q [MSR_NUM];
    logic [63:0] msr_d [MSR_NUM];
    logic [31:0] feat;
    logic [IW-1:0] idx;

    always_comb begin
        feat = '0;
        feat[`FSCIC_FEAT_FLUSH] = FEAT_FLUSH;
        feat[`FSCIC_FEAT_FXSR] = FEAT_FXSR;
        feat[`FSCIC_FEAT_PFX1] = FEAT_PFX1;
        feat[`FSCIC_FEAT_PFX2] = FEAT_PFX2;
    end

    assign idx = i_req.msr_index[IW-1:0];
    assign take = i_req.valid & (st_q == fscic_pkg::FSCIC_RUN);
    assign is_fp = take & (i_req.kind == fscic_pkg::FSCIC_K_FP);
    assign is_wait = take & (i_req.kind == fscic_pkg::FSCIC_K_WAIT);
    assign fault = (is_fp & (~HAS_FPU | trap_all)) | (is_wait & monitor & ts_flag);
    assign hang = is_fp & HAS_FPU & ~trap_all & ~i_fpu_present &
        ~i_coproc_present & ~i_emulator_present;

    always_comb begin
        st_d = st_q;
        done_d = 1'b0;
        flt_d = fault;
        exe_d = is_fp & ~fault & ~hang;
        dreg_d = dreg_q;
        rd_d = rd_q;
        msr_d = msr_q;
        if (hang) begin
            st_d = fscic_pkg::FSCIC_HUNG;
        end else if (take) begin
            done_d = 1'b1;
            unique case (i_req.kind)
                fscic_pkg::FSCIC_K_FEAT: begin
                    dreg_d = (i_req.accumulator_reg == `FSCIC_FEAT_LEAF) ? feat : '0;
                end
                fscic_pkg::FSCIC_K_SRD: begin
                    rd_d = msr_q[idx];
                end
                fscic_pkg::FSCIC_K_SWR: begin
                    msr_d[idx] = i_req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= fscic_pkg::FSCIC_RUN;
            done_q <= 1'b0;
            flt_q <= 1'b0;
            exe_q <= 1'b0;
            dreg_q <= '0;
            rd_q <= '0;
            // Cleared so that range types start uncached
            for (int i = 0; i < MSR_NUM; i++) begin
                msr_q[i] <= '0;
            end
        end else begin
            st_q <= st_d;
            done_q <= done_d;
            flt_q <= flt_d;
            exe_q <= exe_d;
            dreg_q <= dreg_d;
            rd_q <= rd_d;
            msr_q <= msr_d;
        end
    end

    generate
        for (genvar g = 0; g < MTRR_NUM; g++) begin : g_range
            assign o_range_uncached[g] = (msr_q[g][7:0] == `FSCIC_TYPE_UNCACHED);
        end
    endgenerate

    assign o_done = done_q;
    assign o_device_unavailable_fault = flt_q;
    assign o_fp_exec = exe_q;
    assign o_hung = (st_q == fscic_pkg::FSCIC_HUNG);
    assign o_data_reg_d = dreg_q;
    assign o_msr_rdata = rd_q;

    // ************************************************
    // Numeric error routing
    // ************************************************
    logic int_q, int_d, ext_q, ext_d;
    always_comb begin
        int_d = i_unmasked_exc & err_sel;
        ext_d = i_unmasked_exc & ~err_sel;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            int_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            int_q <= int_d;
            ext_q <= ext_d;
        end
    end
    assign o_fp_err_internal = int_q;
    assign o_fp_err_external = ext_q;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_reset_flags: assert property (
        $past(i_srst) |-> (cw0_q[`FSCIC_CW0_TRAP_ALL] == 1'b0)
            && (cw0_q[`FSCIC_CW0_MONITOR] == 1'b0) && (cw0_q[`FSCIC_CW0_ERR_SEL] == 1'b0))
        else $error("fp flags not cleared by reset");
    chk_trap_fault: assert property (
        (is_fp && trap_all) |=> o_device_unavailable_fault && !o_fp_exec)
        else $error("trap-all did not fault");
    chk_fp_exec: assert property (
        (is_fp && !trap_all && HAS_FPU && i_fpu_present) |=> o_fp_exec)
        else $error("fp not executed");
    chk_wait_fault: assert property (
        is_wait |=> (o_device_unavailable_fault == $past(monitor && ts_flag)))
        else $error("wait fault mismatch");
    chk_err_route: assert property (
        i_unmasked_exc |=> (o_fp_err_internal == $past(err_sel))
            && (o_fp_err_external != $past(err_sel)))
        else $error("numeric error misrouted");
    chk_hang_stays: assert property (
        hang |=> o_hung [*4])
        else $error("hang not held");
    chk_variant_fault: assert property (
        (is_fp && !HAS_FPU) |=> o_device_unavailable_fault)
        else $error("no-fpu variant did not fault");
    chk_cache_en: assert property (
        $past(i_srst) |-> !o_cache_enable && cw0_q[`FSCIC_CW0_CACHE_DIS]
            && cw0_q[`FSCIC_CW0_NO_WT])
        else $error("cache enabled after reset");
    chk_lines_invalid: assert property (
        $past(i_srst) |-> (o_line_valid == '0))
        else $error("cache line valid after reset");
    chk_msr_write: assert property (
        (take && i_req.kind == fscic_pkg::FSCIC_K_SWR) |=> (msr_q[$past(idx)] == $past(i_req.wdata)))
        else $error("msr write lost");
    chk_msr_stable: assert property (
        !(take && i_req.kind == fscic_pkg::FSCIC_K_SWR) |=> $stable(msr_q[0]))
        else $error("msr changed without write");
    chk_range_uc: assert property (
        $past(i_srst) |-> (o_range_uncached == '1))
        else $error("range not uncached");
    chk_feat_load: assert property (
        (take && i_req.kind == fscic_pkg::FSCIC_K_FEAT && i_req.accumulator_reg == 32'h1)
            |=> o_data_reg_d[`FSCIC_FEAT_FLUSH] == FEAT_FLUSH
            && o_data_reg_d[`FSCIC_FEAT_PFX1] == FEAT_PFX1)
        else $error("feature flags wrong");
    chk_simd_reset: assert property (
        $past(i_srst) |-> o_simd_fp_control_status == 32'h0000_1F80)
        else $error("simd csr reset value wrong");
    chk_simd_soft: assert property (
        (i_soft_init && !i_simd_wr) |=> $stable(o_simd_fp_control_status))
        else $error("soft init changed simd csr");

    cov_trap: cover property (is_fp && trap_all);
    cov_wait: cover property (is_wait && monitor && ts_flag);
    cov_hang: cover property (hang);
    cov_ext: cover property (i_unmasked_exc && !err_sel);
endmodule

// >>> hw/fscic_defs.svh
// Bit positions, reset values and feature constants of the control block
`ifndef FSCIC_DEFS_SVH
`define FSCIC_DEFS_SVH
`define FSCIC_CW0_MONITOR 1
`define FSCIC_CW0_TRAP_ALL 2
`define FSCIC_CW0_TASK_SW 3
`define FSCIC_CW0_ERR_SEL 5
`define FSCIC_CW0_NO_WT 29
`define FSCIC_CW0_CACHE_DIS 30
`define FSCIC_CW0_RST 32'h6000_0000
`define FSCIC_CW0_KEEP 32'h6000_0000
`define FSCIC_CW4_SAVE 9
`define FSCIC_CW4_EXC 10
`define FSCIC_CW4_RST 32'h0000_0000
`define FSCIC_SIMD_RST 32'h0000_1F80
`define FSCIC_FEAT_FLUSH 19
`define FSCIC_FEAT_FXSR 24
`define FSCIC_FEAT_PFX1 25
`define FSCIC_FEAT_PFX2 26
`define FSCIC_FEAT_LEAF 32'h0000_0001
`define FSCIC_TYPE_UNCACHED 8'h00
`endif

// >>> hw/fscic_pkg.sv
// Types shared by the control block and its environment
package fscic_pkg;
    typedef enum logic [2:0] {
        FSCIC_K_NONE = 3'b000,
        FSCIC_K_FP = 3'b001,
        FSCIC_K_WAIT = 3'b010,
        FSCIC_K_FEAT = 3'b011,
        FSCIC_K_SRD = 3'b100,
        FSCIC_K_SWR = 3'b101
    } fscic_kind_t;
    typedef struct packed {
        logic valid;
        fscic_kind_t kind;
        logic [31:0] accumulator_reg;
        logic [7:0] msr_index;
        logic [63:0] wdata;
    } fscic_req_t;
    typedef enum logic [0:0] {
        FSCIC_RUN = 1'b0,
        FSCIC_HUNG = 1'b1
    } fscic_state_t;
endpackage

// >>> verification/fscic_tb.sv
// Self-checking bench for the floating-point and init control block
`include "fscic_defs.svh"
module tb;
timeunit 1ns;
timeprecision 1ps;
typedef struct {
    fscic_pkg::fscic_kind_t kind;
    logic fault;
    logic exec;
    logic [63:0] val;
} fscic_exp_t;
logic i_clk, i_srst, i_soft_init, i_cw0_wr, i_task_switch, i_cw4_wr, i_simd_wr;
logic [31:0] i_cw0_wdata, i_cw4_wdata, i_simd_wdata;
fscic_pkg::fscic_req_t i_req;
logic i_fpu_present, i_coproc_present, i_emulator_present, i_unmasked_exc, i_line_fill;
logic [2:0] i_line_idx;
logic [31:0] o_control_word_zero, o_control_word_four, o_simd_fp_control_status, o_data_reg_d;
logic o_cache_enable, o_done, o_device_unavailable_fault, o_fp_exec, o_hung;
logic o_fp_err_internal, o_fp_err_external;
logic [7:0] o_line_valid;
logic [3:0] o_range_uncached;
logic [63:0] o_msr_rdata, wd;
int n_mismatch, total_checks;
logic [31:0] seed = 32'hCB1C;
fscic_exp_t exq[$];
fscic_exp_t e;
fscic_ctrl DUT (.i_clk(i_clk), .i_srst(i_srst), .i_soft_init(i_soft_init),
    .i_cw0_wr(i_cw0_wr), .i_cw0_wdata(i_cw0_wdata), .i_task_switch(i_task_switch),
    .i_cw4_wr(i_cw4_wr), .i_cw4_wdata(i_cw4_wdata), .i_simd_wr(i_simd_wr),
    .i_simd_wdata(i_simd_wdata), .i_req(i_req), .i_fpu_present(i_fpu_present),
    .i_coproc_present(i_coproc_present), .i_emulator_present(i_emulator_present),
    .i_unmasked_exc(i_unmasked_exc), .i_line_fill(i_line_fill), .i_line_idx(i_line_idx),
    .o_control_word_zero(o_control_word_zero), .o_control_word_four(o_control_word_four),
    .o_simd_fp_control_status(o_simd_fp_control_status), .o_cache_enable(o_cache_enable),
    .o_line_valid(o_line_valid), .o_range_uncached(o_range_uncached), .o_done(o_done),
    .o_device_unavailable_fault(o_device_unavailable_fault), .o_fp_exec(o_fp_exec),
    .o_hung(o_hung), .o_fp_err_internal(o_fp_err_internal),
    .o_fp_err_external(o_fp_err_external), .o_data_reg_d(o_data_reg_d),
    .o_msr_rdata(o_msr_rdata));
// ****************************************************************
// Helpers
// ****************************************************************
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", name, exp, got);
    end
endtask
task automatic tick();
    @(posedge i_clk);
    #2;
endtask
task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
        $display("RESULT: PASS");
    end else begin
        $display("RESULT: FAIL");
    end
    $finish;
endtask
task automatic reset();
    i_srst = 1'b1;
    repeat (12) tick();
    i_srst = 1'b0;
endtask
// Strobe held one edge, then one quiet edge so the result is visible
task automatic wctl(input int sel, input logic [31:0] d);
    case (sel)
        0: begin i_cw0_wr = 1'b1; i_cw0_wdata = d; end
        1: begin i_cw4_wr = 1'b1; i_cw4_wdata = d; end
        2: begin i_simd_wr = 1'b1; i_simd_wdata = d; end
        default: i_soft_init = 1'b1;
    endcase
    tick();
    {i_cw0_wr, i_cw4_wr, i_simd_wr, i_soft_init, i_task_switch, i_line_fill} = 6'h00;
    tick();
endtask
// Valid stays up between calls so requests can run back to back
task automatic req(input fscic_pkg::fscic_kind_t k, input logic [31:0] acc,
                   input logic [7:0] idx, input logic [63:0] w, input logic fl,
                   input logic ex, input logic [63:0] v);
    i_req = {1'b1, k, acc, idx, w};
    exq.push_back('{k, fl, ex, v});
    tick();
endtask
task automatic idle();
    i_req = '0;
    tick();
endtask
// ****************************************************************
// Clock, monitor, watchdog
// ****************************************************************
initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
end
always @(posedge i_clk) begin
    #1;
    if (o_done === 1'b1) begin
        if (exq.size() == 0) begin
            chk("unexpected done", 64'h0, 64'h1);
        end else begin
            e = exq.pop_front();
            chk("fault", e.fault, o_device_unavailable_fault);
            chk("exec", e.exec, o_fp_exec);
            if (e.kind == fscic_pkg::FSCIC_K_FEAT) begin
                chk("feature", e.val, o_data_reg_d);
            end
            if (e.kind == fscic_pkg::FSCIC_K_SRD) begin
                chk("msr read", e.val, o_msr_rdata);
            end
        end
    end
end
initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    finish_test();
end
// ****************************************************************
// Tests
// ****************************************************************
initial begin
    {i_srst, i_soft_init, i_cw0_wr, i_task_switch, i_cw4_wr, i_simd_wr} = 6'h00;
    {i_cw0_wdata, i_cw4_wdata, i_simd_wdata} = 96'h0;
    i_req = '0;
    {i_fpu_present, i_coproc_present, i_emulator_present} = 3'b100;
    {i_unmasked_exc, i_line_fill, i_line_idx} = 5'h00;
    reset();
    chk("cw0", 32'h6000_0000, o_control_word_zero);
    chk("cw4", 32'h0000_0000, o_control_word_four);
    chk("simd", 32'h0000_1F80, o_simd_fp_control_status);
    chk("uncached", 4'hF, o_range_uncached);
    chk("lines", 8'h00, o_line_valid);
    $display("test reset done");
    i_line_fill = 1'b1;
    i_line_idx = 3'h3;
    wctl(0, 32'h2000_0000);
    chk("enable", 1'b0, o_cache_enable);
    chk("lines", 8'h00, o_line_valid);
    wctl(0, 32'h0000_0000);
    chk("enable", 1'b1, o_cache_enable);
    i_line_fill = 1'b1;
    i_line_idx = rnd() % 8;
    wctl(0, 32'h0000_0000);
    chk("lines", 8'h01 << i_line_idx, o_line_valid);
    $display("test cache done");
    // Setting for a part with no floating-point hardware
    wctl(0, (32'h1 << `FSCIC_CW0_TRAP_ALL) | (32'h1 << `FSCIC_CW0_ERR_SEL));
    req(fscic_pkg::FSCIC_K_FP, 0, 0, 0, 1'b1, 1'b0, 0);
    req(fscic_pkg::FSCIC_K_FP, 0, 0, 0, 1'b1, 1'b0, 0);
    idle();
    wctl(0, 32'h1 << `FSCIC_CW0_MONITOR);
    for (int i = 0; i < 3; i++) begin
        {i_fpu_present, i_coproc_present, i_emulator_present} = 3'b100 >> i;
        req(fscic_pkg::FSCIC_K_FP, 0, 0, 0, 1'b0, 1'b1, 0);
    end
    idle();
    $display("test fp done");
    for (int i = 0; i < 4; i++) begin
        wctl(0, (i[1] << `FSCIC_CW0_MONITOR) | (i[0] << `FSCIC_CW0_TASK_SW));
        req(fscic_pkg::FSCIC_K_WAIT, 0, 0, 0, i[1] & i[0], 1'b0, 0);
        idle();
    end
    i_task_switch = 1'b1;
    wctl(0, 32'h1 << `FSCIC_CW0_MONITOR);
    req(fscic_pkg::FSCIC_K_WAIT, 0, 0, 0, 1'b1, 1'b0, 0);
    idle();
    $display("test wait done");
    for (int i = 0; i < 2; i++) begin
        wctl(0, i << `FSCIC_CW0_ERR_SEL);
        i_unmasked_exc = 1'b1;
        tick();
        // Routing pulses stand for this one cycle only
        chk("err internal", i[0], o_fp_err_internal);
        chk("err external", !i[0], o_fp_err_external);
        i_unmasked_exc = 1'b0;
    end
    $display("test error done");
    wd = 64'h0;
    wd[`FSCIC_FEAT_FLUSH] = 1'b1;
    wd[`FSCIC_FEAT_FXSR] = 1'b1;
    wd[`FSCIC_FEAT_PFX1] = 1'b1;
    wd[`FSCIC_FEAT_PFX2] = 1'b1;
    req(fscic_pkg::FSCIC_K_FEAT, 32'h1, 0, 0, 1'b0, 1'b0, wd);
    req(fscic_pkg::FSCIC_K_FEAT, rnd() | 32'h2, 0, 0, 1'b0, 1'b0, 0);
    for (int i = 0; i < 4; i++) begin
        wd = {rnd(), rnd()};
        wd[7:0] = i[0] ? 8'h06 : 8'h00;
        req(fscic_pkg::FSCIC_K_SWR, 0, i, wd, 1'b0, 1'b0, 0);
        req(fscic_pkg::FSCIC_K_SRD, 0, i, 0, 1'b0, 1'b0, wd);
        idle();
        chk("uncached", !i[0], o_range_uncached[i]);
    end
    $display("test query done");
    wctl(1, 32'h0000_0600);
    chk("cw4", 32'h0000_0600, o_control_word_four);
    wd[31:0] = rnd();
    wctl(2, wd[31:0]);
    wctl(0, 32'h6000_0026);
    wctl(3, 32'h0);
    chk("cw0 soft", 32'h6000_0000, o_control_word_zero);
    chk("simd soft", wd[31:0], o_simd_fp_control_status);
    chk("cw4 soft", 32'h0000_0600, o_control_word_four);
    $display("test soft init done");
    wctl(0, 32'h0);
    {i_fpu_present, i_coproc_present, i_emulator_present} = 3'b000;
    i_req = {1'b1, fscic_pkg::FSCIC_K_FP, 32'h0, 8'h00, 64'h0};
    tick();
    i_req.kind = fscic_pkg::FSCIC_K_FEAT;
    repeat (3) tick();
    idle();
    chk("hung", 1'b1, o_hung);
    reset();
    chk("hung", 1'b0, o_hung);
    chk("pending", 0, exq.size());
    $display("test hang done");
    finish_test();
end
endmodule
